//--- pad_function_select_bench.sv
// self-checking bench for the pad function select block
`timescale 1ns/10ps
module pad_function_select_bench;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   logic                 pclk;
   logic                 presetn;
   logic                 psel;
   logic                 penable;
   logic                 pwrite;
   logic [7:0]           paddr;
   logic [31:0]          pwdata;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic [4:0][15:0]     fn_out;
   logic [4:0][15:0]     fn_oe_n;
   logic [4:0][15:0]     fn_in;
   logic [4:0]           pad_in;
   logic [4:0]           pad_out;
   logic [4:0]           pad_oe_n;
   logic [4:0]           pad_pull_en;
   logic [4:0]           pad_pull_up;
   int                   failures;
   int                   check_count;
   // drive and sample capable modes per pad, pad 0 first
   logic [15:0]          drv [5] = '{16'h0059, 16'h004B, 16'h1163, 16'h1049, 16'h1089};
   logic [15:0]          smp [5] = '{16'h005B, 16'h004B, 16'h106B, 16'h100B, 16'h100B};
   // ---------------------------------------------
   // design
   // ---------------------------------------------
   pfs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fn_out(fn_out), .fn_oe_n(fn_oe_n),
      .fn_in(fn_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up));
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic finish_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   // one apb transfer; ends at the edge where pready was seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         failures++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // pad outputs trail a control write by two registered stages
   task automatic settle();
      repeat (3) @(posedge pclk);
      #1;
   endtask : settle
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_reset();
      settle();
      cmp(32'(pad_oe_n), 32'h1F);
      cmp(32'(pad_out), 32'h0);
      cmp(32'(pad_pull_en), 32'h1F);
      cmp(32'(pad_pull_up), 32'h07);
   endtask : t_reset
   // every code on every pad, unassigned ones included
   task automatic t_modes();
      logic [31:0] rd;
      logic        er;
      for (int p = 0; p < 5; p++)
         for (int m = 0; m < 16; m++)
         begin
            apb(1'b1, 8'(4 * p), 32'(m) | 32'h10, rd, er);
            fn_out[p] <= 16'h1 << m;
            settle();
            cmp(32'(pad_oe_n[p]), 32'(!drv[p][m]));
            cmp(32'(pad_out[p]), 32'(drv[p][m]));
            cmp(32'(fn_in[p]), smp[p][m] ? (32'h1 << m) : 32'h0);
         end
   endtask : t_modes
   task automatic t_pull_off();
      logic [31:0] rd;
      logic        er;
      fn_out[2] <= 16'h0001;
      apb(1'b1, 8'h08, 32'h00, rd, er);
      settle();
      cmp(32'(pad_pull_en[2]), 32'h0);
      cmp(32'(pad_oe_n[2]), 32'h0);
      cmp(32'(pad_out[2]), 32'h1);
      fn_oe_n[2][0] <= 1'b1;
      settle();
      cmp(32'(pad_oe_n[2]), 32'h1);
      fn_oe_n[2][0] <= 1'b0;
      apb(1'b1, 8'h08, 32'h30, rd, er);
      settle();
      cmp(32'(pad_oe_n[2]), 32'h1);
      cmp(32'(pad_pull_en[2]), 32'h0);
      cmp(32'(fn_in[2]), 32'h0);
   endtask : t_pull_off
   task automatic t_regs();
      logic [31:0] rd;
      logic        er;
      pad_in <= 5'h15;
      apb(1'b1, 8'h10, 32'hFFFF_FFC3, rd, er);
      apb(1'b0, 8'h10, 32'h0, rd, er);
      cmp(rd, 32'h0000_0003);
      apb(1'b0, 8'h20, 32'h0, rd, er);
      cmp(rd, 32'h1F15);
      apb(1'b1, 8'h20, 32'h0, rd, er);
      cmp(32'(er), 32'h1);
      apb(1'b0, 8'h24, 32'h0, rd, er);
      cmp(32'(er), 32'h1);
   endtask : t_regs
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial
   begin
      failures = 0;
      check_count = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fn_out = '0;
      fn_oe_n = '0;
      pad_in = 5'h1F;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_modes();
      t_pull_off();
      t_regs();
      finish_test();
   end
endmodule : pad_function_select_bench

//--- pfs_cfg.svh
// constants for the pad function select block
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH
// ---------------------------------------------
// geometry
// ---------------------------------------------
`define PFS_NPAD        5
`define PFS_MODE_W      4
`define PFS_NMODE       16
// ---------------------------------------------
// register map (byte addresses)
// ---------------------------------------------
`define PFS_CTRL_BASE   8'h00
`define PFS_STATUS_ADDR 8'h20
`define PFS_ADDR_W      8
// ---------------------------------------------
// control and status fields
// ---------------------------------------------
`define PFS_MODE_LSB    0
`define PFS_PULL_BIT    4
`define PFS_OFF_BIT     5
`define PFS_MODE_RST    4'h0
`define PFS_PULL_RST    1'b1
`define PFS_OFF_RST     1'b0
`define PFS_ARMED_LSB   8
// ---------------------------------------------
// per-pad mode tables: which modes may drive, which may sample
// pad order: uart_dsp_tx, uart_dsp_rx, uart_b_tx, refclk_zero, refclk_one
// ---------------------------------------------
`define PFS_DRV_MASK    {16'h1089, 16'h1049, 16'h1163, 16'h004B, 16'h0059}
`define PFS_SMP_MASK    {16'h100B, 16'h100B, 16'h106B, 16'h004B, 16'h005B}
`define PFS_PULL_UP_MAP 5'h07
`define PFS_IN_IDLE     1'b0
`endif

//--- pfs_pad_if.sv
// signals between the register side and one pad selector
`timescale 1ns/10ps
interface pfs_pad_if;
   import pfs_pkg::*;
   pfs_mode_t mode;
   logic      armed;
   logic      off;
   logic      pad_in;
   pfs_vec_t  fn_out;
   pfs_vec_t  fn_oe_n;
   logic      sel_out;
   logic      sel_oe_n;
   pfs_vec_t  sel_in;
   modport ctl (output mode, armed, off, pad_in, fn_out, fn_oe_n,
                input sel_out, sel_oe_n, sel_in);
   modport mux (input mode, armed, off, pad_in, fn_out, fn_oe_n,
                output sel_out, sel_oe_n, sel_in);
endinterface : pfs_pad_if

//--- pfs_pad_mux.sv
// one pad: picks the function that drives and samples it
`timescale 1ns/10ps
module pfs_pad_mux
#(
   parameter logic [15:0] DRV_MASK = 16'h0001,
   parameter logic [15:0] SMP_MASK = 16'h0001
)
(
   // selector link
   pfs_pad_if.mux p
);
   import pfs_pkg::*;
   `include "pfs_cfg.svh"

   wire      drv_ok  = DRV_MASK[p.mode];
   wire      smp_ok  = SMP_MASK[p.mode];
   wire      live    = p.armed & ~p.off;
   // unknown mode code: no drive, inputs parked
   wire      drive   = live & drv_ok & ~p.fn_oe_n[p.mode];
   // a net, so the one-hot code follows every mode change
   wire pfs_vec_t one_hot = pfs_vec_t'(16'h0001) << p.mode;

   assign p.sel_out  = drive ? p.fn_out[p.mode] : `PFS_IN_IDLE;
   assign p.sel_oe_n = ~drive;
   // only the selected function sees the pad
   assign p.sel_in   = (~p.off & smp_ok & p.pad_in) ? one_hot
                                                    : {16{`PFS_IN_IDLE}};
endmodule : pfs_pad_mux

//--- pfs_pkg.sv
// types shared by the pad function select block
package pfs_pkg;
   typedef logic [3:0]  pfs_mode_t;
   typedef logic [15:0] pfs_vec_t;
   typedef enum {PFS_BUS_IDLE, PFS_BUS_ACCESS} pfs_bus_state_t;
endpackage : pfs_pkg

//--- pfs_top.sv
// pad function select: apb control registers and per-pad multiplexing
//
// Overview of operation
// - each pad carries the function whose mode number software wrote
// - mode number lives in bits 3..0 of each pad control register
// - mode 0 selects the pad's default, ball-named function
// - after reset every pad keeps its driver off until software writes it
// - software switches each pad's pull resistor on or off; its direction is fixed from the first clock after reset, down on every pad before that
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "pfs_cfg.svh"
module pfs_top
#(
   parameter int NPAD = `PFS_NPAD
)
(
   // clock and reset
   input  wire  logic                       pclk,
   input  wire  logic                       presetn,
   // apb slave
   input  wire  logic                       psel,
   input  wire  logic                       penable,
   input  wire  logic                       pwrite,
   input  wire  logic [7:0]                 paddr,
   input  wire  logic [31:0]                pwdata,
   output       logic [31:0]                prdata,
   output       logic                       pready,
   output       logic                       pslverr,
   // internal function side
   input  wire  logic [NPAD-1:0][15:0]      fn_out,
   input  wire  logic [NPAD-1:0][15:0]      fn_oe_n,
   output       logic [NPAD-1:0][15:0]      fn_in,
   // pads
   input  wire  logic [NPAD-1:0]            pad_in,
   output       logic [NPAD-1:0]            pad_out,
   output       logic [NPAD-1:0]            pad_oe_n,
   output       logic [NPAD-1:0]            pad_pull_en,
   output       logic [NPAD-1:0]            pad_pull_up
);
   import pfs_pkg::*;

   localparam logic [NPAD*16-1:0] DRV_TAB = `PFS_DRV_MASK;
   localparam logic [NPAD*16-1:0] SMP_TAB = `PFS_SMP_MASK;

   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   function automatic logic [2:0] pad_index(input logic [7:0] a);
      logic [7:0] off;
      off = a - `PFS_CTRL_BASE;
      return off[4:2];
   endfunction : pad_index

   function automatic logic is_ctrl(input logic [7:0] a);
      logic [7:0] off;
      off = a - `PFS_CTRL_BASE;
      return (a >= `PFS_CTRL_BASE) && (off[1:0] == 2'h0)
             && (off[7:2] < 6'(NPAD));
   endfunction : is_ctrl

   pfs_bus_state_t  bus_state;
   pfs_mode_t       mode     [NPAD];
   logic [NPAD-1:0] pull_on;
   logic [NPAD-1:0] pad_off;
   logic [NPAD-1:0] armed;
   logic [NPAD-1:0] pad_seen;

   wire        setup_ph  = psel & ~penable;
   wire        access_ph = psel & penable & pready;
   wire        hit_ctrl  = is_ctrl(paddr);
   wire        hit_stat  = (paddr == `PFS_STATUS_ADDR);
   wire  [2:0] widx      = pad_index(paddr);
   wire        wr_ctrl   = access_ph & pwrite & hit_ctrl;
   wire        bad_addr  = ~(hit_ctrl | hit_stat);
   // status register is read only; a write to it is an error
   wire        bad_acc   = bad_addr | (hit_stat & pwrite);

   logic [31:0] rd_word;
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (hit_ctrl)
      begin
         rd_word[`PFS_MODE_LSB +: `PFS_MODE_W] = mode[widx];
         rd_word[`PFS_PULL_BIT]                = pull_on[widx];
         rd_word[`PFS_OFF_BIT]                 = pad_off[widx];
      end
      else if (hit_stat)
      begin
         rd_word[NPAD-1:0]                           = pad_seen;
         rd_word[`PFS_ARMED_LSB +: NPAD]             = armed;
      end
   end

   // ---------------------------------------------
   // apb slave: zero wait states, registered answer
   // ---------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_state <= PFS_BUS_IDLE;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         prdata    <= 32'h0000_0000;
      end
      else
      begin
         case (bus_state)
            PFS_BUS_IDLE:
            begin
               pready    <= setup_ph;
               pslverr   <= setup_ph & bad_acc;
               prdata    <= (setup_ph & ~pwrite) ? rd_word : 32'h0000_0000;
               bus_state <= setup_ph ? PFS_BUS_ACCESS : PFS_BUS_IDLE;
            end
            PFS_BUS_ACCESS:
            begin
               pready    <= 1'b0;
               prdata    <= 32'h0000_0000;
               pslverr   <= 1'b0;
               bus_state <= PFS_BUS_IDLE;
            end
            default:
            begin
               pready    <= 1'b0;
               prdata    <= 32'h0000_0000;
               pslverr   <= 1'b0;
               bus_state <= PFS_BUS_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------
   // pad control registers
   // ---------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < NPAD; i++)
            mode[i] <= `PFS_MODE_RST;
         pull_on <= {NPAD{`PFS_PULL_RST}};
         pad_off <= {NPAD{`PFS_OFF_RST}};
         armed   <= '0;
      end
      else if (wr_ctrl)
      begin
         mode[widx]    <= pwdata[`PFS_MODE_LSB +: `PFS_MODE_W];
         pull_on[widx] <= pwdata[`PFS_PULL_BIT];
         pad_off[widx] <= pwdata[`PFS_OFF_BIT];
         armed[widx]   <= 1'b1;
      end
   end

   // ---------------------------------------------
   // per-pad selectors; every pad output is registered
   // ---------------------------------------------
   logic [NPAD-1:0]       next_out;
   logic [NPAD-1:0]       next_oe_n;
   logic [NPAD-1:0][15:0] next_in;

   for (genvar g = 0; g < NPAD; g++)
   begin : g_pad
      pfs_pad_if pif ();
      assign pif.mode    = mode[g];
      assign pif.armed   = armed[g];
      assign pif.off     = pad_off[g];
      assign pif.pad_in  = pad_in[g];
      assign pif.fn_out  = fn_out[g];
      assign pif.fn_oe_n = fn_oe_n[g];
      assign next_out[g]  = pif.sel_out;
      assign next_oe_n[g] = pif.sel_oe_n;
      assign next_in[g]   = pif.sel_in;
      pfs_pad_mux
      #(
         .DRV_MASK (DRV_TAB[g*16 +: 16]),
         .SMP_MASK (SMP_TAB[g*16 +: 16])
      )
      u_mux
      (
         .p (pif.mux)
      );
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pad_out     <= '0;
         pad_oe_n    <= '1;
         fn_in       <= '0;
         pad_pull_en <= {NPAD{`PFS_PULL_RST}};
         pad_pull_up <= '0;
         pad_seen    <= '0;
      end
      else
      begin
         pad_out     <= next_out;
         pad_oe_n    <= next_oe_n;
         fn_in       <= next_in;
         // a switched-off pad leaves its pull off too
         pad_pull_en <= pull_on & ~pad_off;
         pad_pull_up <= NPAD'(`PFS_PULL_UP_MAP);
         pad_seen    <= pad_in;
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_ctrl_write(int k);
      psel && penable && pready && pwrite && paddr == 8'(k*4);
   endsequence

   a_unwritten_pad_quiet: assert property (
      !armed[0] |=> pad_oe_n[0]) else $error("unwritten pad drives");
   a_mode_field_low: assert property (
      s_ctrl_write(1) |=> mode[1] == $past(pwdata[3:0]))
      else $error("mode field not taken from bits 3..0");
   a_mode_zero_routes: assert property (
      armed[0] && !pad_off[0] && mode[0] == 4'h0 && !fn_oe_n[0][0]
      |=> !pad_oe_n[0] && pad_out[0] == $past(fn_out[0][0]))
      else $error("mode 0 does not route default function");
   a_selected_drives: assert property (
      s_ctrl_write(2) ##1 (pwdata[5] == 1'b0 && mode[2] == 4'h8
                           && !fn_oe_n[2][8]) |=> !pad_oe_n[2])
      else $error("selected output mode does not drive");
   a_pull_follows: assert property (
      s_ctrl_write(3) |=> ##1 pad_pull_en[3] == ($past(pwdata[4], 2)
                                                 && !$past(pwdata[5], 2)))
      else $error("pull enable does not follow control");
   a_unknown_mode_idle: assert property (
      mode[1] == 4'hF |=> pad_oe_n[1] && fn_in[1] == 16'h0000)
      else $error("unassigned mode not parked");
   a_off_pad_silent: assert property (
      pad_off[2] |=> pad_oe_n[2] && fn_in[2] == 16'h0000)
      else $error("switched-off pad still active");
endmodule : pfs_top
